/* File: include/fci_pkg.sv */
// Package of constants and types for the flash command host controller
package fci_pkg;

  // ==========================================================================
  // Widths
  localparam int FCI_AW = 19;
  localparam int FCI_DW = 8;

  // ==========================================================================
  // Command addresses and codes
  localparam logic [18:0] FCI_ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] FCI_ADDR_UNLOCK2 = 19'h002AA;
  localparam logic [18:0] FCI_ADDR_ANY = 19'h00000;
  localparam logic [18:0] FCI_ADDR_MAKER = 19'h00000;
  localparam logic [18:0] FCI_ADDR_PART = 19'h00001;
  localparam logic [18:0] FCI_ADDR_PROT = 19'h00002;
  localparam logic [7:0] FCI_D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FCI_D_UNLOCK2 = 8'h55;
  localparam logic [7:0] FCI_D_RESET = 8'hF0;
  localparam logic [7:0] FCI_D_AUTOSEL = 8'h90;
  localparam logic [7:0] FCI_D_PROGRAM = 8'hA0;
  localparam logic [7:0] FCI_D_BYPASS = 8'h20;
  localparam logic [7:0] FCI_D_BYP_EXIT = 8'h00;
  localparam logic [7:0] FCI_D_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FCI_D_CHIP_ERASE = 8'h10;
  localparam logic [7:0] FCI_D_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] FCI_D_SUSPEND = 8'hB0;
  localparam logic [7:0] FCI_D_RESUME = 8'h30;
  localparam logic [7:0] FCI_PROT_SET = 8'h01;
  localparam int FCI_BLOCK_LSB = 16;

  // ==========================================================================
  // Timing, clock 10 MHz
  localparam int FCI_CLK_MHZ = 10;
  localparam int FCI_ABORT_US = 10;
  localparam int FCI_BLOCK_WIN_US = 50;
  localparam int FCI_SUSPEND_US = 15;
  localparam int FCI_ABORT_CYC = FCI_ABORT_US * FCI_CLK_MHZ;
  localparam int FCI_SUSPEND_CYC = FCI_SUSPEND_US * FCI_CLK_MHZ;
  // Longest time: round down, keep margin of one cycle under the window
  localparam int FCI_BLOCK_WIN_CYC = FCI_BLOCK_WIN_US * FCI_CLK_MHZ - 1;
  localparam int FCI_PHASE_CYC = 2;
  localparam int FCI_CNT_W = 10;
  localparam int FCI_PHASE_W = 2;

  // ==========================================================================
  // Commands taken from the user
  typedef enum logic [3:0] {
    FCI_CMD_RESET1 = 4'h0,
    FCI_CMD_RESET3 = 4'h1,
    FCI_CMD_AUTOSEL = 4'h2,
    FCI_CMD_PROGRAM = 4'h3,
    FCI_CMD_BYPASS = 4'h4,
    FCI_CMD_BYP_PROG = 4'h5,
    FCI_CMD_BYP_RESET = 4'h6,
    FCI_CMD_CHIP_ERASE = 4'h7,
    FCI_CMD_BLOCK_ERASE = 4'h8,
    FCI_CMD_SUSPEND = 4'h9,
    FCI_CMD_RESUME = 4'hA,
    FCI_CMD_READ = 4'hB
  } fci_cmd_t;

  // One bus cycle toward the flash
  typedef struct packed {
    logic write;
    logic [18:0] addr;
    logic [7:0] data;
  } fci_cyc_t;

  // Pins toward the flash
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] address_pins;
    logic [7:0] data_pins_o;
    logic data_pins_oe;
  } fci_pins_t;

endpackage : fci_pkg

/* File: hw/fci_bus_cycle.sv */
// Single bus read or write cycle engine on the flash pins
`timescale 1ns/1ns
`default_nettype none
module fci_bus_cycle
  import fci_pkg::*;
#(
  parameter int PHASE_CYC = FCI_PHASE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Cycle request
  input wire logic start_in,
  input var fci_cyc_t cyc_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  // Flash pins
  output var fci_pins_t pins_out,
  input wire logic [7:0] data_pins_in
);

  typedef enum logic [1:0] {
    FCI_B_IDLE = 2'b00,
    FCI_B_SETUP = 2'b01,
    FCI_B_STROBE = 2'b10,
    FCI_B_HOLD = 2'b11
  } fci_bst_t;

  typedef struct packed {
    fci_bst_t st;
    logic [FCI_PHASE_W-1:0] cnt;
    fci_cyc_t cyc;
    fci_pins_t pins;
    logic done;
    logic [7:0] rdata;
  } fci_bstate_t;

  fci_bstate_t s_r, s_nxt;

  // Setup, strobe, hold phases; OE and WE never low together
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      FCI_B_IDLE: begin
        if (start_in) begin
          s_nxt.cyc = cyc_in;
          s_nxt.st = FCI_B_SETUP;
          s_nxt.cnt = '0;
          s_nxt.pins.address_pins = cyc_in.addr;
          s_nxt.pins.data_pins_o = cyc_in.data;
          s_nxt.pins.data_pins_oe = cyc_in.write;
          s_nxt.pins.ce_n = 1'b0;
        end
      end
      FCI_B_SETUP: begin
        s_nxt.st = FCI_B_STROBE;
        s_nxt.pins.we_n = ~s_r.cyc.write;
        s_nxt.pins.oe_n = s_r.cyc.write;
      end
      FCI_B_STROBE: begin
        if (s_r.cnt == FCI_PHASE_W'(PHASE_CYC - 1)) begin
          s_nxt.st = FCI_B_HOLD;
          s_nxt.rdata = data_pins_in;
          s_nxt.pins.we_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      FCI_B_HOLD: begin
        s_nxt.st = FCI_B_IDLE;
        s_nxt.pins.ce_n = 1'b1;
        s_nxt.pins.data_pins_oe = 1'b0;
        s_nxt.done = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{st: FCI_B_IDLE, cnt: '0, cyc: '0,
               pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, address_pins: '0,
                       data_pins_o: '0, data_pins_oe: 1'b0},
               done: 1'b0, rdata: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_out = (s_r.st != FCI_B_IDLE);
  assign done_out = s_r.done;
  assign rdata_out = s_r.rdata;
  assign pins_out = s_r.pins;

  // Data is only driven while output enable is high
  a_no_contention: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !(s_r.pins.data_pins_oe && !s_r.pins.oe_n))
    else $error("host drives data while flash output enabled");
  a_strobe_excl: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !(!s_r.pins.we_n && !s_r.pins.oe_n) && (s_r.pins.we_n || !s_r.pins.ce_n))
    else $error("read and write strobes overlap");

endmodule : fci_bus_cycle
`default_nettype wire

/* File: hw/fci_host.sv */
// Host controller that issues flash command sequences on the parallel pins
// Behaviour
// - Reset: one F0 write or three-write form
// - Auto select: three writes, mode held
// - Program: four writes, data last
// - Bypass entry: three writes, 20
// - Bypass program: A0 then data
// - High-voltage id read on A9
// - Bypass reset: 90 then 00
// - Block erase: six writes, then the block window flag opens
`timescale 1ns/1ns
`default_nettype none
module fci_host
  import fci_pkg::*;
#(
  parameter int PHASE_CYC = FCI_PHASE_CYC,
  parameter int ABORT_CYC = FCI_ABORT_CYC,
  parameter int SUSPEND_CYC = FCI_SUSPEND_CYC,
  parameter int BLOCK_WIN_CYC = FCI_BLOCK_WIN_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // User command port
  input wire logic cmd_valid_in,
  input wire fci_cmd_t cmd_in,
  input wire logic [18:0] cmd_addr_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic id_voltage_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic bypass_mode_out,
  output logic block_window_out,
  // Flash pins
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic [18:0] address_pins_out,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe_out,
  output logic high_voltage_id_level_out,
  input wire logic [7:0] data_pins_in
);

  typedef enum logic [2:0] {
    FCI_H_IDLE = 3'b000,
    FCI_H_ISSUE = 3'b001,
    FCI_H_WAIT = 3'b010,
    FCI_H_SETTLE = 3'b011,
    FCI_H_RESP = 3'b100
  } fci_hst_t;

  typedef struct packed {
    fci_hst_t st;
    fci_cmd_t cmd;
    logic [18:0] addr;
    logic [7:0] data;
    logic [2:0] idx;
    logic [2:0] len;
    logic [FCI_CNT_W-1:0] cnt;
    logic [FCI_CNT_W-1:0] win;
    logic wopen;
    logic bypass;
    logic erasing;
    logic idv;
    logic ready;
    logic rsp;
    logic [7:0] rdata;
  } fci_hstate_t;

  fci_hstate_t s_r, s_nxt;
  logic bc_start;
  logic bc_busy;
  logic bc_done;
  logic [7:0] bc_rdata;
  fci_cyc_t bc_cyc;
  fci_pins_t pins;

  // Length of each command's write sequence, or one cycle for a read
  function automatic logic [2:0] fci_len(input fci_cmd_t c);
    unique case (c)
      FCI_CMD_RESET1, FCI_CMD_SUSPEND, FCI_CMD_RESUME, FCI_CMD_READ: fci_len = 3'd1;
      FCI_CMD_BYP_PROG, FCI_CMD_BYP_RESET: fci_len = 3'd2;
      FCI_CMD_RESET3, FCI_CMD_AUTOSEL, FCI_CMD_BYPASS: fci_len = 3'd3;
      FCI_CMD_PROGRAM: fci_len = 3'd4;
      FCI_CMD_CHIP_ERASE, FCI_CMD_BLOCK_ERASE: fci_len = 3'd6;
      default: fci_len = 3'd1;
    endcase
  endfunction : fci_len

  // Bus cycle number i of command c; only table sequences exist
  function automatic fci_cyc_t fci_step(input fci_cmd_t c, input logic [2:0] i,
                                        input logic [18:0] a, input logic [7:0] d);
    fci_cyc_t y;
    y = '{write: 1'b1, addr: FCI_ADDR_ANY, data: FCI_D_RESET};
    if (c == FCI_CMD_READ) begin
      y = '{write: 1'b0, addr: a, data: '0};
    end else if (c == FCI_CMD_RESET1) begin
      y.data = FCI_D_RESET;
    end else if (c == FCI_CMD_SUSPEND) begin
      y.data = FCI_D_SUSPEND;
    end else if (c == FCI_CMD_RESUME) begin
      y.data = FCI_D_RESUME;
    end else if (c == FCI_CMD_BYP_PROG) begin
      y = (i == 3'd0) ? fci_cyc_t'{write: 1'b1, addr: FCI_ADDR_ANY, data: FCI_D_PROGRAM}
                      : fci_cyc_t'{write: 1'b1, addr: a, data: d};
    end else if (c == FCI_CMD_BYP_RESET) begin
      y.data = (i == 3'd0) ? FCI_D_AUTOSEL : FCI_D_BYP_EXIT;
    end else if (i == 3'd0 || (i == 3'd3 && c != FCI_CMD_PROGRAM)) begin
      y = '{write: 1'b1, addr: FCI_ADDR_UNLOCK1, data: FCI_D_UNLOCK1};
    end else if (i == 3'd1 || i == 3'd4) begin
      y = '{write: 1'b1, addr: FCI_ADDR_UNLOCK2, data: FCI_D_UNLOCK2};
    end else begin
      y.addr = FCI_ADDR_UNLOCK1;
      unique case (c)
        FCI_CMD_RESET3: y = '{write: 1'b1, addr: FCI_ADDR_ANY, data: FCI_D_RESET};
        FCI_CMD_AUTOSEL: y.data = FCI_D_AUTOSEL;
        FCI_CMD_BYPASS: y.data = FCI_D_BYPASS;
        FCI_CMD_PROGRAM: y = (i == 3'd2) ? y : fci_cyc_t'{write: 1'b1, addr: a, data: d};
        FCI_CMD_CHIP_ERASE: y.data = (i == 3'd2) ? FCI_D_ERASE_SETUP : FCI_D_CHIP_ERASE;
        FCI_CMD_BLOCK_ERASE: begin
          y.data = (i == 3'd2) ? FCI_D_ERASE_SETUP : FCI_D_BLOCK_ERASE;
          y.addr = (i == 3'd2) ? FCI_ADDR_UNLOCK1 : a;
        end
        default: y.data = FCI_D_RESET;
      endcase
      if (c == FCI_CMD_PROGRAM && i == 3'd2) begin
        y.data = FCI_D_PROGRAM;
      end
    end
    return y;
  endfunction : fci_step

  // Command sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp = 1'b0;
    bc_start = 1'b0;
    bc_cyc = fci_step(s_r.cmd, s_r.idx, s_r.addr, s_r.data);
    if (s_r.win != '0) begin
      s_nxt.win = s_r.win - 1'b1;
    end
    unique case (s_r.st)
      FCI_H_IDLE: begin
        s_nxt.ready = 1'b1;
        if (cmd_valid_in && s_r.ready) begin
          s_nxt.ready = 1'b0;
          s_nxt.cmd = cmd_in;
          s_nxt.addr = cmd_addr_in;
          s_nxt.data = cmd_data_in;
          s_nxt.idv = (cmd_in == FCI_CMD_READ) && id_voltage_in;
          s_nxt.idx = '0;
          s_nxt.len = fci_len(cmd_in);
          s_nxt.st = FCI_H_ISSUE;
        end
      end
      FCI_H_ISSUE: begin
        bc_start = 1'b1;
        s_nxt.st = FCI_H_WAIT;
      end
      FCI_H_WAIT: begin
        if (bc_done) begin
          s_nxt.rdata = bc_rdata;
          if (s_r.idx == s_r.len - 3'd1) begin
            s_nxt.st = FCI_H_SETTLE;
            s_nxt.cnt = '0;
            unique case (s_r.cmd)
              FCI_CMD_BYPASS: s_nxt.bypass = 1'b1;
              FCI_CMD_BYP_RESET: s_nxt.bypass = 1'b0;
              FCI_CMD_BLOCK_ERASE: begin
                s_nxt.erasing = 1'b1;
                s_nxt.win = FCI_CNT_W'(BLOCK_WIN_CYC);
              end
              FCI_CMD_CHIP_ERASE: s_nxt.erasing = 1'b1;
              FCI_CMD_RESET1, FCI_CMD_RESET3: s_nxt.win = '0;
              FCI_CMD_RESUME: s_nxt.win = '0;
              default: s_nxt.bypass = s_r.bypass;
            endcase
          end else begin
            s_nxt.idx = s_r.idx + 3'd1;
            s_nxt.st = FCI_H_ISSUE;
          end
        end
      end
      FCI_H_SETTLE: begin
        // Abort and suspend settle times before next command
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (((s_r.cmd == FCI_CMD_RESET1 || s_r.cmd == FCI_CMD_RESET3) &&
             s_r.erasing && s_r.cnt < FCI_CNT_W'(ABORT_CYC)) ||
            (s_r.cmd == FCI_CMD_SUSPEND && s_r.cnt < FCI_CNT_W'(SUSPEND_CYC))) begin
          s_nxt.st = FCI_H_SETTLE;
        end else begin
          s_nxt.st = FCI_H_RESP;
          if (s_r.cmd == FCI_CMD_RESET1 || s_r.cmd == FCI_CMD_RESET3) begin
            s_nxt.erasing = 1'b0;
          end
        end
      end
      FCI_H_RESP: begin
        s_nxt.rsp = 1'b1;
        s_nxt.idv = 1'b0;
        s_nxt.st = FCI_H_IDLE;
      end
      default: s_nxt.st = FCI_H_IDLE;
    endcase
    // Window flag registered so the output comes from a flip-flop
    s_nxt.wopen = (s_nxt.win != '0);
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{st: FCI_H_IDLE, cmd: FCI_CMD_READ, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin cycle engine
  fci_bus_cycle #(.PHASE_CYC(PHASE_CYC)) u_cycle (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .start_in(bc_start),
    .cyc_in(bc_cyc),
    .busy_out(bc_busy),
    .done_out(bc_done),
    .rdata_out(bc_rdata),
    .pins_out(pins),
    .data_pins_in(data_pins_in)
  );

  // Outputs, all from flip-flops
  assign cmd_ready_out = s_r.ready;
  assign rsp_valid_out = s_r.rsp;
  assign rsp_data_out = s_r.rdata;
  assign bypass_mode_out = s_r.bypass;
  assign block_window_out = s_r.wopen;
  assign high_voltage_id_level_out = s_r.idv;
  assign flash_ce_n_out = pins.ce_n;
  assign flash_oe_n_out = pins.oe_n;
  assign flash_we_n_out = pins.we_n;
  assign address_pins_out = pins.address_pins;
  assign data_pins_out = pins.data_pins_o;
  assign data_pins_oe_out = pins.data_pins_oe;

  // ==========================================================================
  // Assertions
  sequence s_take;
    cmd_valid_in && cmd_ready_out;
  endsequence
  sequence s_start;
    s_r.st == FCI_H_ISSUE;
  endsequence

  a_issue_after: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    s_take |=> s_start)
    else $error("accepted command not issued");
  a_no_early_take: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    bc_busy |-> !cmd_ready_out)
    else $error("host ready while bus cycle runs");
  a_reset_abort: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (s_r.st == FCI_H_SETTLE && s_nxt.st == FCI_H_RESP && s_r.erasing &&
     (s_r.cmd == FCI_CMD_RESET1 || s_r.cmd == FCI_CMD_RESET3)) |->
    s_r.cnt >= FCI_CNT_W'(ABORT_CYC))
    else $error("reset abort wait too short");
  a_bypass_set: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $rose(bypass_mode_out) |-> $past(s_r.cmd) == FCI_CMD_BYPASS)
    else $error("bypass set by wrong command");
  a_bypass_clr: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $fell(bypass_mode_out) |-> $past(s_r.cmd) == FCI_CMD_BYP_RESET)
    else $error("bypass cleared by wrong command");
  a_reset_f0: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (bc_start && s_r.cmd == FCI_CMD_RESET1) |-> bc_cyc.data == FCI_D_RESET)
    else $error("reset write has wrong data");
  a_unlock_first: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (bc_start && s_r.idx == 3'd0 && s_r.cmd == FCI_CMD_PROGRAM) |->
    bc_cyc.addr == FCI_ADDR_UNLOCK1 && bc_cyc.data == FCI_D_UNLOCK1)
    else $error("program does not open with unlock");
  a_erase_last: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (bc_start && s_r.idx == 3'd5 && s_r.cmd == FCI_CMD_CHIP_ERASE) |->
    bc_cyc.data == FCI_D_CHIP_ERASE && bc_cyc.addr == FCI_ADDR_UNLOCK1)
    else $error("chip erase last write wrong");
  a_window_load: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $rose(block_window_out) |-> s_r.win == FCI_CNT_W'(BLOCK_WIN_CYC))
    else $error("block window not loaded");

endmodule : fci_host
`default_nettype wire

/* File: dv/fci_flash_model.sv */
// Behavioural flash device model on the parallel pins
`timescale 1ns/1ns
`default_nettype none
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hA7, // Arbitrary value
  parameter logic [7:0] PROT_MASK = 8'h80
) (
  // Host pins
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [18:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  input wire logic hv_in,
  // Device pins
  output logic [7:0] data_out,
  output logic proto_err_out
);
  // ==========================================================================
  // Array and modes
  logic [7:0] mem [int];
  logic [7:0] last_q = 8'h00;
  logic [18:0] wa;
  logic wsel = 1'b0;
  logic autosel = 1'b0;
  logic bypass = 1'b0;
  int step = 0;
  initial proto_err_out = 1'b0;
  initial mem[32'h70010] = 8'h5A; // Byte kept in a protected block

  function automatic logic [7:0] arr(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : arr

  function automatic logic [7:0] rd(input logic [18:0] a);
    if (!(autosel || hv_in)) return arr(int'(a));
    if (a[1:0] == 2'b00) return MAKER_ID;
    if (a[1:0] == 2'b01) return PART_ID;
    return {7'h00, PROT_MASK[a[18:16]]};
  endfunction : rd

  task automatic prog(input logic [18:0] a, input logic [7:0] d);
    if (!PROT_MASK[a[18:16]]) mem[int'(a)] = arr(int'(a)) & d;
  endtask : prog

  task automatic erase(input logic [3:0] b);
    foreach (mem[k]) if ((b[3] || k[18:16] == b[2:0]) && !PROT_MASK[k[18:16]]) mem[k] = 8'hFF;
  endtask : erase

  // ==========================================================================
  // Command decoder
  task automatic decode(input logic [18:0] a, input logic [7:0] d);
    logic u;
    logic v;
    u = (a[10:0] == 11'h555);
    v = (a[10:0] == 11'h2AA);
    autosel = 1'b0;
    if (bypass) begin
      if (step == 10) prog(a, d);
      if (step == 11 && d == 8'h00) bypass = 1'b0;
      step = (step != 0) ? 0 : (d == 8'hA0) ? 10 : (d == 8'h90) ? 11 : 0;
    end else begin
      case (step)
        0: step = (u && d == 8'hAA) ? 1 : 0;
        1: step = (v && d == 8'h55) ? 2 : 0;
        2: begin
          autosel = u && d == 8'h90;
          bypass = u && d == 8'h20;
          step = !u ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
        end
        3: begin
          prog(a, d);
          step = 0;
        end
        4: step = (u && d == 8'hAA) ? 5 : 0;
        5: step = (v && d == 8'h55) ? 6 : 0;
        default: begin
          if (u && d == 8'h10) erase(4'h8);
          if (d == 8'h30) erase({1'b0, a[18:16]});
          step = 0;
        end
      endcase
    end
  endtask : decode

  // Read data only in a read cycle, else the inverse of the last byte
  always @(ce_n_in or oe_n_in or we_n_in or addr_in or hv_in) begin
    if (!ce_n_in && !oe_n_in && we_n_in) begin
      data_out = rd(addr_in);
      last_q = data_out;
    end else begin
      data_out = ~last_q;
    end
  end
  // Address and select taken once the write strobe has fallen
  always @(negedge we_n_in) begin
    #1;
    wsel = !ce_n_in;
    wa = addr_in;
    if (wsel && !oe_n_in) proto_err_out = 1'b1;
  end
  // Every completed write reaches the decoder
  always @(posedge we_n_in) begin
    if (wsel && data_oe_in !== 1'b1) proto_err_out = 1'b1;
    if (wsel) decode(wa, data_in);
    wsel = 1'b0;
  end
  // Host must release the data pins during a read
  always @(negedge oe_n_in) begin
    #1;
    if (!ce_n_in && data_oe_in) proto_err_out = 1'b1;
  end
endmodule : fci_flash_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking testbench of the flash command host controller
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import fci_pkg::*;
;
  // ==========================================================================
  // Signals and notes
  localparam int ABORT = 4;
  localparam int SUSP = 5;
  localparam int WIN = 20;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART = 8'hA7; // Arbitrary value
  localparam logic [7:0] PROT = 8'h80;
  typedef struct packed {
    logic chk;
    logic [7:0] val;
    logic [15:0] lat;
  } fci_tb_note_t;
  logic sys_clk_in, resetn_in, cmd_valid_in, id_voltage_in, proto_err;
  fci_cmd_t cmd_in;
  logic [18:0] cmd_addr_in, address_pins_out;
  logic [7:0] cmd_data_in, rsp_data_out, data_pins_out, data_pins_in;
  logic cmd_ready_out, rsp_valid_out, bypass_mode_out, block_window_out;
  logic flash_ce_n_out, flash_oe_n_out, flash_we_n_out, data_pins_oe_out;
  logic high_voltage_id_level_out;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int t_take = 0;
  int seed = 90;
  int erased = 0;
  int nwr [12] = '{1, 3, 3, 4, 3, 2, 2, 6, 6, 1, 1, 1};
  fci_tb_note_t notes[$];

  fci_host #(.ABORT_CYC(ABORT), .SUSPEND_CYC(SUSP), .BLOCK_WIN_CYC(WIN)) dut (
    .sys_clk_in, .resetn_in, .cmd_valid_in, .cmd_in, .cmd_addr_in, .cmd_data_in,
    .id_voltage_in, .cmd_ready_out, .rsp_valid_out, .rsp_data_out, .bypass_mode_out,
    .block_window_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out,
    .address_pins_out, .data_pins_out, .data_pins_oe_out, .high_voltage_id_level_out,
    .data_pins_in
  );
  fci_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .PROT_MASK(PROT)) flash (
    .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
    .addr_in(address_pins_out), .data_in(data_pins_out), .data_oe_in(data_pins_oe_out),
    .hv_in(high_voltage_id_level_out), .data_out(data_pins_in), .proto_err_out(proto_err)
  );

  // ==========================================================================
  // Clock, cycle count and shared tasks
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) cyc <= cyc + 1;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic wait_ready;
    int k;
    k = 0;
    while (cmd_ready_out !== 1'b1 && k < 3000) begin
      @(negedge sys_clk_in);
      k++;
    end
    if (k == 3000) check("ready wait", 16'h1, 16'h0);
  endtask : wait_ready

  // One command: note the expectation, hold the request until taken
  task automatic run(input fci_cmd_t c, input logic [18:0] a, input logic [7:0] d,
                     input logic hv, input logic chk, input logic [7:0] v);
    fci_tb_note_t n;
    logic rst;
    rst = (c == FCI_CMD_RESET1 || c == FCI_CMD_RESET3);
    n.chk = chk;
    n.val = v;
    n.lat = 16'(nwr[int'(c)] * 6 + 3 + (c == FCI_CMD_SUSPEND ? SUSP : 0) + (rst && erased != 0 ? ABORT : 0));
    if (rst) erased = 0;
    if (c == FCI_CMD_CHIP_ERASE || c == FCI_CMD_BLOCK_ERASE) erased = 1;
    wait_ready();
    cmd_valid_in = 1'b1;
    cmd_in = c;
    cmd_addr_in = a;
    cmd_data_in = d;
    id_voltage_in = hv;
    notes.push_back(n);
    @(posedge sys_clk_in);
    t_take = cyc;
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
    id_voltage_in = 1'b0;
  endtask : run

  task automatic rd(input logic [18:0] a, input logic [7:0] v);
    run(FCI_CMD_READ, a, 8'h00, 1'b0, 1'b1, v);
  endtask : rd

  task automatic wr(input fci_cmd_t c, input logic [18:0] a, input logic [7:0] d);
    run(c, a, d, 1'b0, 1'b0, 8'h00);
  endtask : wr

  // Watcher: oldest note against each completion
  always @(posedge sys_clk_in) begin : watch
    fci_tb_note_t n;
    int lt;
    if (rsp_valid_out === 1'b1) begin
      n = notes.size() != 0 ? notes.pop_front() : '0;
      lt = cyc - t_take;
      if (n.chk) check("read data", {8'h00, n.val}, {8'h00, rsp_data_out});
      check("latency", n.lat, 16'(lt));
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin : main
    int i;
    logic [7:0] rv [4];
    resetn_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = FCI_CMD_READ;
    cmd_addr_in = 19'h00000;
    cmd_data_in = 8'h00;
    id_voltage_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    check("ce in reset", 16'h1, {15'h0, flash_ce_n_out});
    check("data oe in reset", 16'h0, {15'h0, data_pins_oe_out});
    resetn_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rd(19'h12345, 8'hFF);
    wr(FCI_CMD_PROGRAM, 19'h12345, 8'h3C);
    rd(19'h12345, 8'h3C);
    wr(FCI_CMD_PROGRAM, 19'h12345, 8'hF0);
    rd(19'h12345, 8'h30);
    wr(FCI_CMD_PROGRAM, 19'h70010, 8'h00);
    rd(19'h70010, 8'h5A);
    wr(FCI_CMD_AUTOSEL, 19'h00000, 8'h00);
    rd(19'h5A000, MAKER);
    rd(19'h2C001, PART);
    for (i = 0; i < 8; i++) rd({i[2:0], 16'h4002}, {7'h00, PROT[i]});
    wr(FCI_CMD_RESET3, 19'h00000, 8'h00);
    rd(19'h12345, 8'h30);
    run(FCI_CMD_READ, 19'h00200, 8'h00, 1'b1, 1'b1, MAKER);
    run(FCI_CMD_READ, 19'h00201, 8'h00, 1'b1, 1'b1, PART);
    wr(FCI_CMD_BYPASS, 19'h00000, 8'h00);
    wait_ready();
    check("bypass on", 16'h1, {15'h0, bypass_mode_out});
    for (i = 0; i < 4; i++) begin
      rv[i] = 8'($random(seed));
      wr(FCI_CMD_BYP_PROG, 19'h30000 + 19'(i), rv[i]);
      rd(19'h30000 + 19'(i), rv[i]);
    end
    wr(FCI_CMD_BYP_RESET, 19'h00000, 8'h00);
    wait_ready();
    check("bypass off", 16'h0, {15'h0, bypass_mode_out});
    rd(19'h30000, rv[0]);
    wr(FCI_CMD_BLOCK_ERASE, 19'h12000, 8'h00);
    wait_ready();
    check("window open", 16'h1, {15'h0, block_window_out});
    repeat (WIN + 2) @(negedge sys_clk_in);
    check("window closed", 16'h0, {15'h0, block_window_out});
    rd(19'h12345, 8'hFF);
    wr(FCI_CMD_SUSPEND, 19'h00000, 8'h00);
    wr(FCI_CMD_RESUME, 19'h00000, 8'h00);
    wr(FCI_CMD_RESET1, 19'h00000, 8'h00);
    wr(FCI_CMD_CHIP_ERASE, 19'h00000, 8'h00);
    rd(19'h30001, 8'hFF);
    rd(19'h70010, 8'h5A);
    wr(FCI_CMD_RESET1, 19'h00000, 8'h00);
    rd(19'h12345, 8'hFF);
    wait_ready();
    check("notes left", 16'h0, 16'(notes.size()));
    check("pin protocol", 16'h0, {15'h0, proto_err});
    summarize();
  end

  // Watchdog against a hang
  initial begin : watchdog
    #(20000 * 100);
    err_total++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
